// >>> hdl/otp_test_master.sv
/*
  Host end: AXI4-Lite slave with frame, status and control registers,
  a serial frame engine that makes the link clock by division, and an
  automatic post-start hold-off and status poll.
  Assumes a single bus master on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module otp_test_master
  import otp_port_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYCLES = PROG_MAX_CYCLES
)(
  input wire logic CORE_CLK,
  input wire logic NRST,
  otp_link_if.host LINK,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  typedef struct packed {
    frame_state_t fs;
    logic [3:0] half_cnt;
    logic [4:0] bit_cnt;
    logic [15:0] tx;
    logic [7:0] rx;
    logic sclk;
    logic din;
    logic test_en;
    logic dout_s1;
    logic dout_s2;
    poll_state_t pp;
    logic [16:0] timer;
    logic poll_done;
    logic prog_fail;
    logic timeout;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic busy;
  logic frame_end;
  logic [15:0] sw_frame;

  // msb first: address, direction, spare, data
  function automatic logic [15:0] make_frame(input logic [5:0] a, input logic rw, input logic [7:0] d);
    return {a, rw, 1'b0, d};
  endfunction

  always_comb begin
    next_s = s;
    next_s.dout_s1 = LINK.ser_dout;
    next_s.dout_s2 = s.dout_s1;
    busy = (s.fs != FS_IDLE) || (s.pp != PP_OFF);
    frame_end = 1'b0;
    sw_frame = make_frame(WDATA[HF_ADDR_MSB:HF_ADDR_LSB], WDATA[HF_RW_BIT], WDATA[7:0]);

    // frame engine: link clock made by dividing the core clock
    case (s.fs)
      FS_IDLE: begin
      end
      FS_LOW: begin
        if (s.half_cnt == 4'h0) begin
          next_s.sclk = 1'b1;
          next_s.rx = {s.rx[6:0], s.dout_s2};
          next_s.bit_cnt = s.bit_cnt + 5'h01;
          next_s.half_cnt = SCLK_HALF_LAST;
          next_s.fs = FS_HIGH;
        end else begin
          next_s.half_cnt = s.half_cnt - 4'h1;
        end
      end
      FS_HIGH: begin
        if (s.half_cnt == 4'h0) begin
          next_s.sclk = 1'b0;
          next_s.half_cnt = SCLK_HALF_LAST;
          if (s.bit_cnt == FRAME_BITS) begin
            next_s.fs = FS_IDLE;
            frame_end = 1'b1;
          end else begin
            next_s.tx = {s.tx[14:0], 1'b0};
            next_s.din = s.tx[14];
            next_s.fs = FS_LOW;
          end
        end else begin
          next_s.half_cnt = s.half_cnt - 4'h1;
        end
      end
      default: begin
        next_s.fs = FS_IDLE;
      end
    endcase

    // hold-off, then poll the status byte
    case (s.pp)
      PP_OFF: begin
      end
      PP_HOLD: begin
        if (s.fs == FS_IDLE) begin
          if (s.timer == PROG_START_LAST) begin
            next_s.timer = 17'h0_0000;
            next_s.pp = PP_POLL;
          end else begin
            next_s.timer = s.timer + 17'h0_0001;
          end
        end
      end
      PP_POLL: begin
        if (s.timer != 17'h1_FFFF) begin
          next_s.timer = s.timer + 17'h0_0001;
        end
        if (frame_end) begin
          if (s.rx[ST_DONE_BIT]) begin
            next_s.poll_done = 1'b1;
            next_s.prog_fail = s.rx[ST_FAIL_BIT];
            next_s.pp = PP_OFF;
          end else if (s.timer >= 17'(PROG_TIMEOUT_CYCLES)) begin
            next_s.timeout = 1'b1;
            next_s.pp = PP_OFF;
          end
        end else if (s.fs == FS_IDLE) begin
          next_s.tx = make_frame(ADDR_PROG_STAT, 1'b0, 8'h00);
          next_s.din = ADDR_PROG_STAT[5];
          next_s.sclk = 1'b0;
          next_s.bit_cnt = 5'h00;
          next_s.half_cnt = SCLK_HALF_LAST;
          next_s.fs = FS_LOW;
        end
      end
      default: begin
        next_s.pp = PP_OFF;
      end
    endcase

    // write channel: address and data taken together
    next_s.awready = 1'b0;
    next_s.wready = 1'b0;
    if (AWVALID && WVALID && !s.awready && !s.bvalid) begin
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.awready && AWVALID && WVALID) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (AWADDR == HOST_FRAME) begin
        if (busy) begin
          // one frame at a time; a refused frame is not queued
          next_s.bresp = RESP_SLVERR;
        end else begin
          next_s.tx = sw_frame;
          next_s.din = sw_frame[15];
          next_s.sclk = 1'b0;
          next_s.bit_cnt = 5'h00;
          next_s.half_cnt = SCLK_HALF_LAST;
          next_s.fs = FS_LOW;
          if (sw_frame == make_frame(ADDR_PROG_CTRL, 1'b1, CTRL_PROG_START)) begin
            next_s.pp = PP_HOLD;
            next_s.timer = 17'h0_0000;
            next_s.poll_done = 1'b0;
            next_s.prog_fail = 1'b0;
            next_s.timeout = 1'b0;
          end
        end
      end else if (AWADDR == HOST_CTRL) begin
        if (WSTRB[0]) begin
          next_s.test_en = WDATA[HC_TEST_BIT];
        end
      end else if (AWADDR != HOST_STATUS) begin
        next_s.bresp = RESP_SLVERR;
      end
    end

    // read channel
    next_s.arready = 1'b0;
    if (ARVALID && !s.arready && !s.rvalid) begin
      next_s.arready = 1'b1;
    end
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && ARVALID) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (ARADDR == HOST_STATUS) begin
        next_s.rdata[HS_BUSY_BIT] = busy;
        next_s.rdata[HS_DONE_BIT] = s.poll_done;
        next_s.rdata[HS_FAIL_BIT] = s.prog_fail;
        next_s.rdata[HS_TIMEOUT_BIT] = s.timeout;
        next_s.rdata[HS_RX_LSB +: 8] = s.rx;
      end else if (ARADDR == HOST_CTRL) begin
        next_s.rdata[HC_TEST_BIT] = s.test_en;
      end else if (ARADDR != HOST_FRAME) begin
        next_s.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign LINK.ser_clk = s.sclk;
  assign LINK.ser_din = s.din;
  assign LINK.test_supply = s.test_en;
  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;

endmodule
`default_nettype wire

// >>> common/otp_port_pkg.sv
/*
  Shared constants and types for the test-mode serial register port and
  its fuse programming sequencer: frame layout, register map, key values,
  status bit positions and timing counts.
  Assumes a single 50 MHz core clock on both ends of the link.
*/
package otp_port_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 20;

  // frame layout, msb first: addr[5:0], rw, unused, data[7:0]
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] RISE_ADDR_DONE = 5'h07;
  localparam logic [4:0] RISE_OUT_FIRST = 5'h08;
  localparam logic [4:0] RISE_OUT_LAST = 5'h0F;
  localparam int FR_ADDR_MSB = 15;
  localparam int FR_ADDR_LSB = 10;
  localparam int FR_RW_BIT = 9;
  localparam int FR_DATA_MSB = 7;

  // device register map
  localparam logic [5:0] ADDR_MIRROR_BASE = 6'h06;
  localparam logic [5:0] MIRROR_COUNT = 6'h0A;
  localparam logic [5:0] ADDR_PROG_CTRL = 6'h20;
  localparam logic [5:0] ADDR_PROG_STAT = 6'h29;
  localparam logic [5:0] ADDR_UNLOCK_KEY = 6'h30;

  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [7:0] KEY_THIRD = 8'hC6;
  localparam logic [7:0] CTRL_MIRROR_WRITE = 8'h00;
  localparam logic [7:0] CTRL_PROG_START = 8'h05;

  // status byte at ADDR_PROG_STAT
  localparam int ST_LOCK_BIT = 6;
  localparam int ST_DONE_BIT = 5;
  localparam int ST_FAIL_BIT = 4;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_TEST_BIT = 2;

  // final lock lives in config word b
  localparam logic [3:0] LOCK_SLOT = 4'h1;
  localparam int LOCK_BIT = 7;

  // timing
  localparam int LOAD_CYCLES_I = 16;
  localparam logic [4:0] LOAD_CYCLES = 5'(LOAD_CYCLES_I);
  localparam int BURN_SLOT_NS = 10000;
  localparam int BURN_SLOT_CYCLES = BURN_SLOT_NS / CLK_PERIOD_NS;
  localparam logic [8:0] BURN_LAST = 9'(BURN_SLOT_CYCLES - 1);
  localparam int SCLK_HALF_MIN_NS = 250;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);
  localparam int PROG_START_WAIT_NS = 32000;
  localparam int PROG_START_WAIT_CYCLES = (PROG_START_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [16:0] PROG_START_LAST = 17'(PROG_START_WAIT_CYCLES - 1);
  localparam int PROG_MAX_NS = 2000000;
  localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;

  // host register map (byte addresses on the lite bus)
  localparam logic [7:0] HOST_FRAME = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_CTRL = 8'h08;
  localparam int HF_RW_BIT = 16;
  localparam int HF_ADDR_MSB = 13;
  localparam int HF_ADDR_LSB = 8;
  localparam int HS_BUSY_BIT = 0;
  localparam int HS_DONE_BIT = 1;
  localparam int HS_FAIL_BIT = 2;
  localparam int HS_TIMEOUT_BIT = 3;
  localparam int HS_RX_LSB = 8;
  localparam int HC_TEST_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PS_IDLE = 2'h0, PS_BURN = 2'h1, PS_CHECK = 2'h3} prog_state_t;
  typedef enum logic [1:0] {FS_IDLE = 2'h0, FS_LOW = 2'h1, FS_HIGH = 2'h3} frame_state_t;
  typedef enum logic [1:0] {PP_OFF = 2'h0, PP_HOLD = 2'h1, PP_POLL = 2'h3} poll_state_t;

endpackage

// >>> common/otp_link_if.sv
/*
  Serial link between the external test master and the register port.
  Assumes the bench instantiates it once and joins both ends to it.
*/
`timescale 1ns/10ps
`default_nettype none
interface otp_link_if;
  logic ser_clk;
  logic ser_din;
  logic ser_dout;
  logic test_supply;
  modport device (input ser_clk, input ser_din, input test_supply, output ser_dout);
  modport host (output ser_clk, output ser_din, output test_supply, input ser_dout);
endinterface
`default_nettype wire

// >>> hdl/otp_reg_port.sv
/*
  Device end: test-mode serial register port, fuse mirrors, unlock key
  check and automatic fuse programming sequencer.
  Assumes the link pins come from another clock domain and that the
  master keeps the frame format; fuse storage is modelled in flip-flops.
*/
// How it works
// - fuses programmable only in unlocked test mode
// - master writes keys AA, 55, C6
// - 00 to control enables mirror writes
// - 05 to control starts programming
// - master waits 32 us before polling
// - status bit 5 shows finished
// - status bit 4 shows failure
// - fuse bits only go zero to one
// - final lock rejects further fuse changes
// - final lock enables normal-mode parity check
// - sixteen-bit frame: address, direction, data
// - direction one writes, zero reads
// - read data out on falls 8-15
// - write data in on rises 9-16
// - write frame returns prior contents
// - no resync; reset recovers framing
// - fuses copied to mirrors in sixteen cycles
// - mirror writes need permission bit
// - sample on rise, shift on fall
// - port live only with test supply
// - programming ends within 2 ms
`timescale 1ns/10ps
`default_nettype none
module otp_reg_port
  import otp_port_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  otp_link_if.device LINK,
  output logic PARITY_CHECK_EN,
  output logic TEST_MODE_ACTIVE
);

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic din_s1;
    logic din_s2;
    logic ten_s1;
    logic ten_s2;
    logic [4:0] rise_cnt;
    logic [15:0] rx;
    logic [7:0] rd_buf;
    logic dout;
    logic [9:0][7:0] mirror;
    logic [9:0][7:0] fuse;
    logic [7:0] ctrl;
    logic [1:0] key_stage;
    logic test_mode;
    logic wr_en;
    logic fail;
    logic [4:0] load_cnt;
    prog_state_t ps;
    logic [3:0] ploc;
    logic [8:0] pcnt;
    logic plock;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;
  logic rise;
  logic fall;
  logic [15:0] frame;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic [4:0] wslot;

  // {hit, index} for the ten mirror locations
  function automatic logic [4:0] mirror_slot(input logic [5:0] a);
    logic [5:0] off;
    off = a - ADDR_MIRROR_BASE;
    return {(a >= ADDR_MIRROR_BASE) && (off < MIRROR_COUNT), off[3:0]};
  endfunction

  function automatic logic [7:0] reg_value(input dev_state_t st, input logic [5:0] a);
    logic [4:0] slot;
    logic [7:0] v;
    slot = mirror_slot(a);
    v = 8'h00;
    if (slot[4]) begin
      v = st.mirror[slot[3:0]];
    end else if (a == ADDR_PROG_CTRL) begin
      v = st.ctrl;
    end else if (a == ADDR_PROG_STAT) begin
      v[ST_LOCK_BIT] = st.fuse[LOCK_SLOT][LOCK_BIT];
      v[ST_DONE_BIT] = st.wr_en;
      v[ST_FAIL_BIT] = st.fail;
      v[ST_BUSY_BIT] = (st.ps != PS_IDLE);
      v[ST_TEST_BIT] = st.test_mode;
    end
    return v;
  endfunction

  always_comb begin
    next_s = s;
    // pins cross in through two flops each
    next_s.sclk_s1 = LINK.ser_clk;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_d = s.sclk_s2;
    next_s.din_s1 = LINK.ser_din;
    next_s.din_s2 = s.din_s1;
    next_s.ten_s1 = LINK.test_supply;
    next_s.ten_s2 = s.ten_s1;
    rise = s.sclk_s2 & ~s.sclk_d;
    fall = ~s.sclk_s2 & s.sclk_d;
    frame = {s.rx[14:0], s.din_s2};
    waddr = frame[FR_ADDR_MSB:FR_ADDR_LSB];
    wdata = frame[FR_DATA_MSB:0];
    wslot = mirror_slot(waddr);

    // power-up copy of fuses into mirrors
    if (s.load_cnt != LOAD_CYCLES) begin
      next_s.load_cnt = s.load_cnt + 5'h01;
      if (s.load_cnt < 5'(MIRROR_COUNT)) begin
        next_s.mirror[s.load_cnt[3:0]] = s.fuse[s.load_cnt[3:0]];
      end
    end

    if (!s.ten_s2) begin
      // without test supply the port is dead and test mode drops
      next_s.rise_cnt = 5'h00;
      next_s.dout = 1'b0;
      next_s.test_mode = 1'b0;
      next_s.key_stage = 2'h0;
      next_s.wr_en = 1'b0;
    end else begin
      if (rise && s.rise_cnt != FRAME_BITS) begin
        next_s.rise_cnt = s.rise_cnt + 5'h01;
        next_s.rx = frame;
        if (s.rise_cnt + 5'h01 == RISE_ADDR_DONE) begin
          // snapshot before any write of this frame lands
          next_s.rd_buf = reg_value(s, s.rx[5:0]);
        end
        if (s.rise_cnt + 5'h01 == FRAME_BITS && frame[FR_RW_BIT]) begin
          if (waddr == ADDR_UNLOCK_KEY) begin
            next_s.key_stage = 2'h0;
            if (s.key_stage == 2'h0 && wdata == KEY_FIRST) begin
              next_s.key_stage = 2'h1;
            end else if (s.key_stage == 2'h1 && wdata == KEY_SECOND) begin
              next_s.key_stage = 2'h2;
            end else if (s.key_stage == 2'h2 && wdata == KEY_THIRD) begin
              next_s.test_mode = 1'b1;
            end
          end else if (waddr == ADDR_PROG_CTRL) begin
            next_s.ctrl = wdata;
            if (s.test_mode && wdata == CTRL_MIRROR_WRITE) begin
              next_s.wr_en = 1'b1;
            end else if (s.test_mode && wdata == CTRL_PROG_START && s.wr_en && s.ps == PS_IDLE) begin
              next_s.wr_en = 1'b0;
              next_s.fail = 1'b0;
              next_s.ploc = 4'h0;
              next_s.pcnt = 9'h000;
              next_s.plock = s.fuse[LOCK_SLOT][LOCK_BIT];
              if (s.fuse[LOCK_SLOT][LOCK_BIT]) begin
                // locked array: finish at once and report failure
                next_s.fail = 1'b1;
                next_s.wr_en = 1'b1;
              end else begin
                next_s.ps = PS_BURN;
              end
            end
          end else if (wslot[4] && s.test_mode && s.wr_en && s.ps == PS_IDLE && s.load_cnt == LOAD_CYCLES) begin
            next_s.mirror[wslot[3:0]] = wdata;
          end
        end
      end
      if (fall) begin
        if (s.rise_cnt >= RISE_OUT_FIRST && s.rise_cnt <= RISE_OUT_LAST) begin
          next_s.dout = s.rd_buf[7];
          next_s.rd_buf = {s.rd_buf[6:0], 1'b0};
        end else begin
          next_s.dout = 1'b0;
        end
        // only the frame's last fall rearms; a lost edge stays lost until reset or loss of test supply
        if (s.rise_cnt == FRAME_BITS) begin
          next_s.rise_cnt = 5'h00;
        end
      end
    end

    // one slot every BURN_SLOT_CYCLES, ten slots well inside the limit
    case (s.ps)
      PS_IDLE: begin
      end
      PS_BURN: begin
        if (s.pcnt == BURN_LAST) begin
          next_s.pcnt = 9'h000;
          if (!s.plock) begin
            next_s.fuse[s.ploc] = s.fuse[s.ploc] | s.mirror[s.ploc];
          end
          if (s.ploc == 4'(MIRROR_COUNT - 6'h01)) begin
            next_s.ps = PS_CHECK;
          end else begin
            next_s.ploc = s.ploc + 4'h1;
          end
        end else begin
          next_s.pcnt = s.pcnt + 9'h001;
        end
      end
      PS_CHECK: begin
        // a zero asked over a burnt one cannot be met
        next_s.fail = (s.fuse != s.mirror);
        next_s.wr_en = 1'b1;
        next_s.ps = PS_IDLE;
      end
      default: begin
        next_s.ps = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign LINK.ser_dout = s.dout;
  assign PARITY_CHECK_EN = s.fuse[LOCK_SLOT][LOCK_BIT];
  assign TEST_MODE_ACTIVE = s.test_mode;

endmodule
`default_nettype wire

// >>> tb/otp_link_sva.sv
/*
  Checker for the serial link between the two ends: clock phases, output
  timing and window, test mode and lock flags.
  Assumes the core clock samples every link signal.
*/
`timescale 1ns/10ps
`default_nettype none
module otp_link_sva (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic ser_clk,
  input wire logic ser_din,
  input wire logic ser_dout,
  input wire logic test_supply,
  input wire logic PARITY_CHECK_EN,
  input wire logic TEST_MODE_ACTIVE
);
  logic [3:0] fall_age;
  logic [4:0] rc;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // rise count per frame; frames are always 16 rises, so no idle detection
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      fall_age <= 4'hF;
      rc <= 5'h00;
    end else begin
      fall_age <= $fell(ser_clk) ? 4'h0 : (fall_age == 4'hF ? fall_age : fall_age + 4'h1);
      if ($rose(ser_clk)) rc <= (rc == 5'h10) ? 5'h01 : rc + 5'h01;
    end
  end
  property p_clk_high; $rose(ser_clk) |=> ser_clk [*8] ##1 ser_clk [*4]; endproperty
  property p_clk_low; $fell(ser_clk) |=> !ser_clk [*8] ##1 !ser_clk [*4]; endproperty
  property p_din_low; $changed(ser_din) |-> !ser_clk; endproperty
  property p_dout_fall; $changed(ser_dout) |-> fall_age <= 4'h6; endproperty
  property p_dout_window; ser_dout |-> rc >= 5'h08; endproperty
  property p_dout_dead; !test_supply [*8] |-> !ser_dout; endproperty
  property p_mode_supply; !test_supply [*4] |-> !TEST_MODE_ACTIVE; endproperty
  property p_mode_frame; $rose(TEST_MODE_ACTIVE) |-> rc == 5'h10; endproperty
  property p_lock_sticky; PARITY_CHECK_EN |=> PARITY_CHECK_EN; endproperty
  property p_lock_test; $rose(PARITY_CHECK_EN) |-> TEST_MODE_ACTIVE; endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high too short");
  a_clk_low: assert property (p_clk_low) else $error("link clock low too short");
  a_din_low: assert property (p_din_low) else $error("data in moved while clock high");
  a_dout_fall: assert property (p_dout_fall) else $error("data out moved away from a fall");
  a_dout_window: assert property (p_dout_window) else $error("data out high outside its bits");
  a_dout_dead: assert property (p_dout_dead) else $error("data out without test supply");
  a_mode_supply: assert property (p_mode_supply) else $error("test mode without supply");
  a_mode_frame: assert property (p_mode_frame) else $error("test mode entered mid frame");
  a_lock_sticky: assert property (p_lock_sticky) else $error("parity enable dropped");
  a_lock_test: assert property (p_lock_test) else $error("lock burnt outside test mode");
  c_mode: cover property ($rose(TEST_MODE_ACTIVE));
  c_lock: cover property ($rose(PARITY_CHECK_EN));
  c_out: cover property (ser_dout && rc == 5'h0F);
  c_off: cover property ($fell(test_supply));
endmodule
`default_nettype wire

// >>> tb/test_mode_otp_register_port_test.sv
/*
  Bench joining host and device ends over the link; drives the lite bus.
  Assumes the package constants and a 50 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_mode_otp_register_port_test;
  import otp_port_pkg::*;
  localparam int LIMIT = 90000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rnd = 8'h55;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, par_en, test_on;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] seen_frame = 16'h0000;
  logic [7:0] mv [10];
  logic [7:0] keys [5] = '{KEY_FIRST, 8'h11, KEY_FIRST, KEY_SECOND, KEY_THIRD};
  int last_rise = 0, long_gaps = 0;
  int fail_count = 0, n_checks = 0, cyc = 0;
  otp_link_if link ();
  otp_reg_port otp_reg_port_inst (.CORE_CLK(core_clk), .NRST(nrst), .LINK(link.device),
    .PARITY_CHECK_EN(par_en), .TEST_MODE_ACTIVE(test_on));
  otp_test_master #(.PROG_TIMEOUT_CYCLES(20000)) otp_test_master_inst (.CORE_CLK(core_clk), .NRST(nrst),
    .LINK(link.host), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  otp_link_sva otp_link_sva_inst (.CORE_CLK(core_clk), .NRST(nrst), .ser_clk(link.ser_clk),
    .ser_din(link.ser_din), .ser_dout(link.ser_dout), .test_supply(link.test_supply),
    .PARITY_CHECK_EN(par_en), .TEST_MODE_ACTIVE(test_on));
  always #10 core_clk = ~core_clk;
  always @(posedge link.ser_clk) begin
    seen_frame <= {seen_frame[14:0], link.ser_din};
    // only the post-start hold-off leaves such a long quiet stretch
    if (cyc - last_rise >= PROG_START_WAIT_CYCLES) long_gaps++;
    last_rise = cyc;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] frame_word(input logic [5:0] a, input logic rw, input logic [7:0] d);
    return {a, rw, 1'b0, d};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // one software frame, then wait until the host is idle again
  task automatic frame(input logic [5:0] a, input logic rw, input logic [7:0] d, output logic [31:0] st);
    logic [1:0] r;
    axi_wr(HOST_FRAME, {15'h0000, rw, 2'b00, a, d}, r);
    check("frame resp", 32'(r), 32'(RESP_OKAY));
    st = 32'h0000_0001;
    for (int i = 0; i < 20000 && st[HS_BUSY_BIT] !== 1'b0; i++) axi_rd(HOST_STATUS, st, r);
    check("frame idle", 32'(st[HS_BUSY_BIT]), 32'h0000_0000);
    // auto-poll frames overwrite the captured bits after a start
    if (!(a == ADDR_PROG_CTRL && d == CTRL_PROG_START)) check("frame bits", 32'(seen_frame), 32'(frame_word(a, rw, d)));
    check("clock idle", 32'(link.ser_clk), 32'h0000_0000);
  endtask
  task automatic rd_dev(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [31:0] st;
    frame(a, 1'b0, 8'h00, st);
    check(what, 32'(st[15:8]), 32'(exp));
  endtask
  task automatic prog(input logic [2:0] exp);
    logic [31:0] st;
    int n0;
    n0 = long_gaps;
    frame(ADDR_PROG_CTRL, 1'b1, CTRL_PROG_START, st);
    check("prog result", 32'(st[HS_TIMEOUT_BIT:HS_DONE_BIT]), 32'(exp));
    check("hold-off", 32'(long_gaps - n0), 32'h0000_0001);
  endtask
  initial begin
    logic [31:0] st;
    logic [1:0] r;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    axi_rd(HOST_CTRL, st, r);
    check("ctrl reset", st, 32'h0000_0000);
    axi_rd(8'h0C, st, r);
    check("unmapped read", 32'(r), 32'(RESP_SLVERR));
    axi_wr(8'h10, 32'h0000_0001, r);
    check("unmapped write", 32'(r), 32'(RESP_SLVERR));
    axi_wr(HOST_CTRL, 32'h0000_0001, r);
    $display("test host registers done");
    // a wrong key restarts the sequence
    for (int k = 0; k < 5; k++) begin
      frame(ADDR_UNLOCK_KEY, 1'b1, keys[k], st);
      check("test mode", 32'(test_on), 32'(k == 4));
    end
    rd_dev(ADDR_PROG_STAT, 8'h04, "status unlocked");
    frame(ADDR_MIRROR_BASE, 1'b1, 8'hFF, st);
    rd_dev(ADDR_MIRROR_BASE, 8'h00, "mirror guarded");
    frame(ADDR_PROG_CTRL, 1'b1, CTRL_MIRROR_WRITE, st);
    rd_dev(ADDR_PROG_STAT, 8'h24, "permission");
    $display("test unlock done");
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      mv[i] = (i == 1) ? (rnd & 8'h7F) : ((i == 2) ? (rnd | 8'h01) : rnd);
      frame(ADDR_MIRROR_BASE + 6'(i), 1'b1, mv[i], st);
      check("prior contents", 32'(st[15:8]), 32'h0000_0000);
      rd_dev(ADDR_MIRROR_BASE + 6'(i), mv[i], "mirror readback");
    end
    prog(3'b001);
    $display("test first burn done");
    frame(ADDR_MIRROR_BASE + 6'h02, 1'b1, 8'h00, st);
    check("prior contents", 32'(st[15:8]), 32'(mv[2]));
    prog(3'b011);
    frame(ADDR_MIRROR_BASE + 6'h02, 1'b1, mv[2], st);
    frame(ADDR_MIRROR_BASE + 6'h01, 1'b1, mv[1] | 8'h80, st);
    prog(3'b001);
    check("parity on", 32'(par_en), 32'h0000_0001);
    rd_dev(ADDR_PROG_STAT, 8'h64, "locked status");
    prog(3'b011);
    $display("test lock done");
    axi_wr(HOST_CTRL, 32'h0000_0000, r);
    repeat (8) @(posedge core_clk);
    check("mode off", 32'(test_on), 32'h0000_0000);
    rd_dev(ADDR_MIRROR_BASE, 8'h00, "port dead");
    // dead port never reports done, so only the poll limit ends the wait
    prog(3'b100);
    $display("test supply off done");
    wrap_up();
  end
endmodule
`default_nettype wire
